//--- axis_encoder_model.sv
// Behavioural encoder and reference switch of the axis
`timescale 1ns/10ps
module axis_encoder_model #(
  parameter int gap = 6
) (
  // Clock
  input wire logic core_clk,
  // Pins towards the block
  output logic count_pulse,
  output logic count_up,
  output logic reference_switch
);
  initial begin
    count_pulse = 1'b0;
    count_up = 1'b1;
    reference_switch = 1'b0;
  end
  // ==========
  // Direction settles long before the edge, as a real encoder does
  task automatic step(input logic up, input int slow);
    count_up <= up;
    repeat (gap + slow) @(posedge core_clk);
    count_pulse <= 1'b1;
    repeat (gap) @(posedge core_clk);
    count_pulse <= 1'b0;
    repeat (gap) @(posedge core_clk);
  endtask
  task automatic cross_switch();
    reference_switch <= 1'b1;
    repeat (2 * gap) @(posedge core_clk);
    reference_switch <= 1'b0;
  endtask
endmodule // axis_encoder_model

//--- axis_reference_sync.sv
// Hardware reference-point synchronisation of an incremental axis
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - Arm rising edge clears ref-valid, arms
// - Armed switch edge, then a right-direction pulse, loads reference, sets flags
// - Move start with arm high rearms
// - Wrong-direction first pulse discards the edge
// - Resynchronisation allowed during a move
// - Target shifts by new minus old position when the sync completes during a move
// - Arming accepted regardless of prior sync
// - Completion sets pos-valid, always ref-valid
// - Every new arm edge rearms and clears
// - Unrefreshed status may miss ref-valid
// - Positioning refused without pos-valid
module axis_reference_sync
  import axis_reference_sync_pkg::*;
#(
  parameter int pos_width = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Axis pins
  input wire logic reference_switch,
  input wire logic count_pulse,
  input wire logic count_up,
  input wire logic jog_forward_request,
  // Status and interrupt
  output logic pos_valid,
  output logic ref_valid,
  output logic irq
);
  // ==========================================================
  // Pin synchronisation
  logic [3:0] pins_sync;
  input_synchronizer #(.width(4)) pin_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in({jog_forward_request, count_up, count_pulse, reference_switch}),
    .level_out(pins_sync)
  );
  logic switch_level;
  logic pulse_level;
  logic up_level;
  logic jog_level;
  assign switch_level = pins_sync[0];
  assign pulse_level = pins_sync[1];
  assign up_level = pins_sync[2];
  assign jog_level = pins_sync[3];

  logic switch_prev;
  logic pulse_prev;
  logic jog_prev;
  logic switch_rise;
  logic pulse_rise;
  logic jog_rise;
  assign switch_rise = switch_level & ~switch_prev;
  assign pulse_rise = pulse_level & ~pulse_prev;
  assign jog_rise = jog_level & ~jog_prev;

  // ==========================================================
  // Registers
  logic [31:0] ctrl;
  logic [pos_width-1:0] reference_position_value;
  logic [pos_width-1:0] actual_position;
  logic [pos_width-1:0] target_position;
  logic [irq_width-1:0] irq_status;
  logic [irq_width-1:0] irq_mask;
  logic ctrl_prev_arm;
  logic refused;
  sync_state_type sync_state;
  sync_state_type next_sync_state;

  // ==========================================================
  // APB decode
  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_status;
  logic hit_ref;
  logic hit_pos;
  logic hit_target;
  logic hit_irq_status;
  logic hit_irq_mask;
  logic hit_any;
  assign wr_en = psel & penable & pwrite;
  // Read data is captured in the setup cycle so it already stands when pready is sampled
  assign rd_en = psel & ~penable & ~pwrite;
  assign hit_ctrl = paddr == ctrl_offset;
  assign hit_status = paddr == status_offset;
  assign hit_ref = paddr == ref_value_offset;
  assign hit_pos = paddr == position_offset;
  assign hit_target = paddr == target_offset;
  assign hit_irq_status = paddr == irq_status_offset;
  assign hit_irq_mask = paddr == irq_mask_offset;
  assign hit_any = hit_ctrl | hit_status | hit_ref | hit_pos | hit_target | hit_irq_status | hit_irq_mask;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // ==========================================================
  // Move control
  logic arm_level;
  logic arm_rise;
  logic dir_forward;
  logic move_request;
  logic move_start;
  logic jog_start;
  logic moving;
  logic [31:0] next_ctrl;
  assign next_ctrl = (wr_en & hit_ctrl) ? pwdata : ctrl;
  assign arm_level = ctrl[ctrl_arm_bit];
  assign arm_rise = arm_level & ~ctrl_prev_arm;
  assign dir_forward = ctrl[ctrl_dir_bit];
  // Writing the move bit is a start request, a one-cycle strobe
  assign move_request = wr_en & hit_ctrl & pwdata[ctrl_move_bit];
  assign move_start = move_request & pos_valid;
  assign jog_start = (wr_en & hit_ctrl & pwdata[ctrl_jog_bit]) | jog_rise;
  logic any_start;
  assign any_start = move_start | jog_start;

  // ==========================================================
  // Synchronisation sequence
  logic rearm;
  logic pulse_ok;
  logic sync_done;
  logic sync_discard;
  // Arming also works mid-move, giving resynchronisation
  assign rearm = arm_rise | (any_start & arm_level);
  assign pulse_ok = pulse_rise & (up_level == dir_forward);
  // A switch edge is judged by the very next counting pulse only
  assign sync_done = (sync_state == sync_wait_pulse) & pulse_ok & ~rearm;
  assign sync_discard = (sync_state == sync_wait_pulse) & pulse_rise & ~pulse_ok & ~rearm;

  always_comb begin
    next_sync_state = sync_state;
    case (sync_state)
      sync_idle: begin
        if (rearm) begin
          next_sync_state = sync_armed;
        end
      end
      sync_armed: begin
        if (switch_rise & ~rearm) begin
          next_sync_state = sync_wait_pulse;
        end
      end
      sync_wait_pulse: begin
        if (rearm) begin
          next_sync_state = sync_armed;
        end else if (pulse_rise) begin
          next_sync_state = sync_idle;
        end
      end
      default: begin
        next_sync_state = sync_idle;
      end
    endcase
  end

  // ==========================================================
  // Position arithmetic
  logic signed [pos_width-1:0] step;
  logic [pos_width-1:0] next_position;
  logic [pos_width-1:0] shift;
  assign step = up_level ? pos_width'(1) : '1;
  assign shift = reference_position_value - actual_position;
  // The pulse that confirms direction is absorbed by the load
  assign next_position = sync_done ? reference_position_value
                       : (pulse_rise ? actual_position + step : actual_position);

  // ==========================================================
  // Interrupt events
  logic [irq_width-1:0] irq_events;
  logic [irq_width-1:0] irq_clear;
  assign irq_events = {move_request & ~pos_valid, sync_discard, sync_done};
  assign irq_clear = (wr_en & hit_irq_status) ? pwdata[irq_width-1:0] : '0;
  // Set wins over a simultaneous clear
  assign irq = |(irq_status & irq_mask);

  // ==========================================================
  // Read mux
  logic [31:0] status_word;
  logic [31:0] read_word;
  assign status_word = {27'h0, refused, moving, sync_state != sync_idle, ref_valid, pos_valid};
  assign read_word = hit_ctrl ? ctrl
                   : hit_status ? status_word
                   : hit_ref ? 32'(reference_position_value)
                   : hit_pos ? 32'(actual_position)
                   : hit_target ? 32'(target_position)
                   : hit_irq_status ? {29'h0, irq_status}
                   : hit_irq_mask ? {29'h0, irq_mask}
                   : 32'h00000000;

  // ==========================================================
  // Synchronisation state and status flags
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_state <= sync_idle;
      pos_valid <= 1'b0;
      ref_valid <= 1'b0;
    end else begin
      sync_state <= next_sync_state;
      if (sync_done) begin
        pos_valid <= 1'b1;
        ref_valid <= 1'b1;
      end else if (rearm) begin
        ref_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control register and edge history
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl <= ctrl_reset_value;
      ctrl_prev_arm <= 1'b0;
      switch_prev <= 1'b0;
      pulse_prev <= 1'b0;
      jog_prev <= 1'b0;
    end else begin
      // Start strobes are not stored, so a later write cannot replay them
      ctrl <= {next_ctrl[31:4], 2'b00, next_ctrl[1:0]};
      ctrl_prev_arm <= arm_level;
      switch_prev <= switch_level;
      pulse_prev <= pulse_level;
      jog_prev <= jog_level;
    end
  end

  // ==========================================================
  // Reference, actual and target position
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reference_position_value <= '0;
      actual_position <= '0;
      target_position <= '0;
    end else begin
      if (wr_en & hit_ref) begin
        reference_position_value <= pwdata[pos_width-1:0];
      end
      actual_position <= next_position;
      // A resync outranks a target write in the same cycle
      if (sync_done & moving) begin
        target_position <= target_position + shift;
      end else if (wr_en & hit_target) begin
        target_position <= pwdata[pos_width-1:0];
      end
    end
  end

  // ==========================================================
  // Move flags
  always_ff @(posedge core_clk) begin
    if (reset) begin
      moving <= 1'b0;
      refused <= 1'b0;
    end else begin
      if (any_start) begin
        moving <= 1'b1;
      end else if (wr_en & hit_ctrl & ~pwdata[ctrl_move_bit] & ~pwdata[ctrl_jog_bit] & ~jog_level) begin
        moving <= 1'b0;
      end
      if (move_request) begin
        refused <= ~pos_valid;
      end
    end
  end

  // ==========================================================
  // Interrupt registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_status <= irq_reset_value;
      irq_mask <= irq_reset_value;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      if (wr_en & hit_irq_mask) begin
        irq_mask <= pwdata[irq_width-1:0];
      end
    end
  end

  // ==========================================================
  // Read data register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= read_word;
    end
  end
endmodule // axis_reference_sync

//--- axis_reference_sync_bench.sv
// Self-checking bench for the axis reference synchronisation block
`timescale 1ns/10ps
module axis_reference_sync_bench;
  import axis_reference_sync_pkg::*;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic count_pulse, count_up, reference_switch, jog_forward_request, pos_valid, ref_valid, irq;
  int miscompares = 0;
  int samples_checked = 0;
  axis_reference_sync i_axis_reference_sync (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .reference_switch, .count_pulse, .count_up, .jog_forward_request,
    .pos_valid, .ref_valid, .irq);
  axis_encoder_model i_axis_encoder_model (.core_clk, .count_pulse, .count_up, .reference_switch);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========
  // Setup, then access until pready; read data and error are taken at that same edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    jog_forward_request = 1'b0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    apb(0, status_offset, 0);
    check("status", rd, 32'h0);
    apb(1, irq_mask_offset, 32'h7);
    apb(1, ref_value_offset, 32'h100);
    apb(1, ctrl_offset, 32'h6);
    apb(0, status_offset, 0);
    check("refused", rd, 32'h10);
    check("irq", irq, 1'b1);
    apb(1, irq_status_offset, 32'h4);
    check("irq off", irq, 1'b0);
    jog_forward_request <= 1'b1;
    repeat (8) @(posedge core_clk);
    jog_forward_request <= 1'b0;
    apb(1, ctrl_offset, 32'h3);
    apb(0, status_offset, 0);
    check("armed", rd[3:0], 4'hc);
    i_axis_encoder_model.cross_switch();
    i_axis_encoder_model.step(1'b0, 0);
    i_axis_encoder_model.step(1'b1, 0);
    apb(0, irq_status_offset, 0);
    check("discard", rd[1:0], 2'h2);
    check("no sync", {pos_valid, ref_valid}, 2'h0);
    apb(1, irq_status_offset, 32'h7);
    apb(1, ctrl_offset, 32'h2);
    apb(1, ctrl_offset, 32'h3);
    i_axis_encoder_model.cross_switch();
    i_axis_encoder_model.step(1'b1, 20);
    repeat (10) @(posedge core_clk);
    apb(0, status_offset, 0);
    check("synced", rd[1:0], 2'h3);
    apb(0, position_offset, 0);
    check("position", rd, 32'h100);
    apb(1, irq_mask_offset, 32'h0);
    check("masked", irq, 1'b0);
    apb(1, irq_mask_offset, 32'h1);
    check("unmasked", irq, 1'b1);
    apb(1, irq_status_offset, 32'h1);
    check("cleared", irq, 1'b0);
    apb(1, target_offset, 32'h200);
    apb(1, ctrl_offset, 32'h7);
    check("move rearm", ref_valid, 1'b0);
    i_axis_encoder_model.step(1'b1, 0);
    i_axis_encoder_model.step(1'b1, 0);
    apb(0, position_offset, 0);
    check("counted", rd, 32'h102);
    apb(1, ref_value_offset, 32'h300);
    i_axis_encoder_model.cross_switch();
    i_axis_encoder_model.step(1'b1, 0);
    repeat (10) @(posedge core_clk);
    apb(0, position_offset, 0);
    check("resync", rd, 32'h300);
    apb(0, target_offset, 0);
    check("target", rd, 32'h3fe);
    check("ref again", ref_valid, 1'b1);
    apb(0, 12'h01c, 0);
    check("pslverr", err, 1'b1);
    final_report();
  end
endmodule // axis_reference_sync_bench

//--- axis_reference_sync_pkg.sv
// Constants and types for the axis reference synchronisation block
package axis_reference_sync_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] ctrl_offset = 12'h000;
  localparam logic [11:0] status_offset = 12'h004;
  localparam logic [11:0] ref_value_offset = 12'h008;
  localparam logic [11:0] position_offset = 12'h00c;
  localparam logic [11:0] target_offset = 12'h010;
  localparam logic [11:0] irq_status_offset = 12'h014;
  localparam logic [11:0] irq_mask_offset = 12'h018;
  // ==========================================================
  // Control fields
  localparam int ctrl_arm_bit = 0;
  localparam int ctrl_dir_bit = 1;
  localparam int ctrl_move_bit = 2;
  localparam int ctrl_jog_bit = 3;
  localparam logic [31:0] ctrl_reset_value = 32'h00000000;
  // Status fields
  localparam int stat_pos_valid_bit = 0;
  localparam int stat_ref_valid_bit = 1;
  localparam int stat_armed_bit = 2;
  localparam int stat_moving_bit = 3;
  localparam int stat_refused_bit = 4;
  // Interrupt events
  localparam int irq_width = 3;
  localparam int irq_sync_bit = 0;
  localparam int irq_discard_bit = 1;
  localparam int irq_refuse_bit = 2;
  localparam logic [irq_width-1:0] irq_reset_value = 3'h0;
  // ==========================================================
  // Synchronisation states
  typedef enum logic [1:0] {sync_idle, sync_armed, sync_wait_pulse} sync_state_type;
endpackage

//--- axis_reference_sync_sva.sv
// Property checker for the axis reference synchronisation block
`timescale 1ns/10ps
module axis_reference_sync_sva
  import axis_reference_sync_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic count_pulse,
  input wire logic count_up,
  input wire logic jog_forward_request,
  input wire logic pos_valid,
  input wire logic ref_valid
);
  logic arm_q;
  logic dir_q;
  logic up_q;
  logic pulse_q;
  logic jog_q;
  logic [3:0] age;
  logic [3:0] jog_age;
  wire wr_ctrl = psel && penable && pwrite && paddr == ctrl_offset;
  // A start with arming already high clears at once; a fresh arm edge acts one cycle later
  wire start_rearm = wr_ctrl && arm_q && (pwdata[ctrl_jog_bit] || (pwdata[ctrl_move_bit] && pos_valid));
  wire arm_edge = wr_ctrl && pwdata[ctrl_arm_bit] && !arm_q;
  // ==========
  // Raw pin history; the ages allow for the synchroniser delay
  always_ff @(posedge core_clk) begin
    pulse_q <= count_pulse;
    jog_q <= jog_forward_request;
    if (reset) begin
      arm_q <= 1'b0;
      dir_q <= 1'b0;
      age <= 4'hf;
      jog_age <= 4'hf;
    end else begin
      if (wr_ctrl) begin
        arm_q <= pwdata[ctrl_arm_bit];
        dir_q <= pwdata[ctrl_dir_bit];
      end
      if (count_pulse && !pulse_q) begin
        up_q <= count_up;
        age <= 4'h0;
      end else if (age != 4'hf) begin
        age <= age + 4'h1;
      end
      if (jog_forward_request && !jog_q) begin
        jog_age <= 4'h0;
      end else if (jog_age != 4'hf) begin
        jog_age <= jog_age + 4'h1;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_rearm; start_rearm; endsequence
  sequence s_arm_edge; arm_edge ##1 1'b1; endsequence
  property p_reset_clear; $fell(reset) |-> !pos_valid && !ref_valid; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("flags set after reset");
  property p_rearm_clear; s_rearm |=> !ref_valid; endproperty
  a_rearm_clear: assert property (p_rearm_clear) else $error("ref valid kept at start");
  property p_arm_clear; s_arm_edge |=> !ref_valid; endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("ref valid kept at arming");
  property p_fall_cause;
    $fell(ref_valid) |-> $past(start_rearm) || $past(arm_edge, 2) || jog_age <= 4'h8;
  endproperty
  a_fall_cause: assert property (p_fall_cause) else $error("ref valid fell unarmed");
  property p_pos_sticky; !$fell(pos_valid); endproperty
  a_pos_sticky: assert property (p_pos_sticky) else $error("pos valid dropped");
  property p_rise_together; $rose(pos_valid) |-> $rose(ref_valid); endproperty
  a_rise_together: assert property (p_rise_together) else $error("pos valid alone");
  property p_ref_implies_pos; ref_valid |-> pos_valid; endproperty
  a_ref_implies_pos: assert property (p_ref_implies_pos) else $error("ref without pos");
  property p_pulse_recent; $rose(ref_valid) |-> age <= 4'ha; endproperty
  a_pulse_recent: assert property (p_pulse_recent) else $error("sync without pulse");
  property p_dir_match; $rose(ref_valid) |-> up_q == dir_q; endproperty
  a_dir_match: assert property (p_dir_match) else $error("sync on wrong direction");
endmodule // axis_reference_sync_sva
bind axis_reference_sync axis_reference_sync_sva i_sva (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .count_pulse, .count_up, .jog_forward_request, .pos_valid, .ref_valid);

//--- input_synchronizer.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module input_synchronizer #(
  parameter int width = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pin side
  input wire logic [width-1:0] pin_in,
  // Core side
  output logic [width-1:0] level_out
);
  logic [width-1:0] stage1;
  logic [width-1:0] stage2;
  logic [width-1:0] stage3;
  logic [width-1:0] next_level;

  // Only the second stage reads the first one
  assign next_level = (stage2 == stage3) ? stage3 : level_out;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level_out <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level_out <= next_level;
    end
  end
endmodule // input_synchronizer
